/* hw/crc_pkg.sv */
// Package with constants and types for the converter reset control block.
package crc_pkg;

    // Minimum external reset pulse and the host wait after reset.
    localparam int EXT_MIN_NS      = 25;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int HOST_WAIT_NS    = 2000;
    // Least time rounds up, at least one cycle.
    localparam int EXT_MIN_CYC     = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOST_WAIT_CYC   = (HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles the core spends in RELEASE, still in reset, after the one HOLD cycle that follows the last source releasing.
    localparam int CORE_HOLD_CYC   = 4;
    localparam int CNT_W           = 8;
    // Reset value of the software reset bit.
    localparam logic SW_BIT_RESET  = 1'b1;
    // Positions of the sources in the source vector.
    localparam int SRC_POR         = 0;
    localparam int SRC_SW          = 1;
    localparam int SRC_EXT         = 2;
    localparam int SRC_W           = 3;

    // Sequencer states, Gray coded along the path.
    typedef enum logic [1:0] {
        CRC_HOLD    = 2'b00,
        CRC_RELEASE = 2'b01,
        CRC_WAIT    = 2'b11,
        CRC_READY   = 2'b10
    } crc_state_t;

    // Status bundle shown to the rest of the core.
    typedef struct packed {
        logic              core_reset;
        logic              host_ready;
        logic              first_frame;
        logic [SRC_W-1:0]  sources;
    } crc_status_t;

endpackage

/* hw/crc_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module crc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic reset,
    // Level in and synchronised level out.
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // The first flop feeds only the second flop.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* hw/crc_top.sv */
// Reset sequencer combining power-on, software and external resets.
`timescale 1ns/10ps
module crc_top #(
    parameter int HOLD_CYC = crc_pkg::CORE_HOLD_CYC,
    parameter int WAIT_CYC = crc_pkg::HOST_WAIT_CYC
) (
    // Clock and power-on reset from the detector.
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // External active-low reset pin.
    input  wire logic              ext_reset_n,
    // Software reset bit write port from the configuration register.
    input  wire logic              sw_bit_we,
    input  wire logic              sw_bit_wdata,
    // Serial frame sync / chip select pin, active low.
    input  wire logic              frame_sync_chip_select_n,
    // Software reset bit readback.
    output logic                   software_reset_bit,
    // Reset to the digital core, active high.
    output logic                   core_reset,
    // Serial data out forced to all ones during the first frame.
    output logic                   force_ones,
    // Status bundle.
    output crc_pkg::crc_status_t   status
);
    localparam int CW = crc_pkg::CNT_W;

    // Counts that the counter cannot hold are refused at elaboration.
    if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CW) ||
        WAIT_CYC < 1 || WAIT_CYC >= (1 << CW)) begin : g_bad_counts
        $error("crc_top: counts out of range");
    end

    // Synchronised pins.
    logic ext_n_s;
    logic fs_n_s;

    crc_sync #(.RESET_VAL(1'b0)) u_ext_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       (ext_reset_n),
        .q       (ext_n_s)
    );

    crc_sync #(.RESET_VAL(1'b1)) u_fs_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       (frame_sync_chip_select_n),
        .q       (fs_n_s)
    );

    // Software bit, sequencer and first-frame state.
    logic                 sw_bit_q, sw_bit_d;
    crc_pkg::crc_state_t  state_q, state_d;
    logic [CW-1:0]        cnt_q, cnt_d;
    logic                 first_q, first_d;
    logic                 fs_prev_q, fs_prev_d;
    logic                 ones_q, ones_d;
    logic [crc_pkg::SRC_W-1:0] src;
    logic                 any_src;

    // Sources: power-on is the async reset itself; sw bit low; pin low.
    always_comb begin
        src = '0;
        src[crc_pkg::SRC_POR] = 1'b0;          // Power-on handled by the async reset.
        // A stored zero starts one reset; masking it while held lets the core leave HOLD.
        src[crc_pkg::SRC_SW]  = ~sw_bit_q & ~core_reset;
        src[crc_pkg::SRC_EXT] = ~ext_n_s;      // Pin low requests reset.
        any_src = |src;                        // Any source holds the core.
    end

    // Next-state logic for the sequencer and the software bit.
    always_comb begin
        sw_bit_d  = sw_bit_q;
        state_d   = state_q;
        cnt_d     = cnt_q;
        first_d   = first_q;
        fs_prev_d = fs_n_s;
        ones_d    = ones_q;
        if (sw_bit_we && !sw_bit_wdata) begin
            sw_bit_d = 1'b0;                   // Software reset request.
        end
        if (any_src) begin
            state_d = crc_pkg::CRC_HOLD;       // Stay held while any source is active.
            cnt_d   = '0;
            first_d = 1'b1;
            ones_d  = 1'b0;
        end else begin
            case (state_q)
                crc_pkg::CRC_HOLD: begin
                    state_d = crc_pkg::CRC_RELEASE;
                    cnt_d   = '0;
                end
                crc_pkg::CRC_RELEASE: begin
                    if (cnt_q == CW'(HOLD_CYC - 1)) begin
                        state_d = crc_pkg::CRC_WAIT;
                        cnt_d   = '0;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                crc_pkg::CRC_WAIT: begin
                    if (cnt_q == CW'(WAIT_CYC - 1)) begin
                        state_d = crc_pkg::CRC_READY;  // Host wait elapsed.
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                crc_pkg::CRC_READY: begin
                    state_d = crc_pkg::CRC_READY;
                end
                default: begin
                    state_d = crc_pkg::CRC_HOLD;
                end
            endcase
        end
        // Bit returns to one in RELEASE while the core is still held, unless a zero write comes in the same cycle.
        if (state_q == crc_pkg::CRC_RELEASE && !(sw_bit_we && !sw_bit_wdata)) begin
            sw_bit_d = crc_pkg::SW_BIT_RESET;
        end
        // First frame after reset drives ones until the frame ends.
        if (!any_src && state_q != crc_pkg::CRC_HOLD) begin
            if (fs_prev_q && !fs_n_s && first_q) begin
                ones_d  = 1'b1;
                first_d = 1'b0;
            end else if (!fs_prev_q && fs_n_s) begin
                ones_d = 1'b0;
            end
        end
    end

    // Registers; power-on reset places everything at defaults.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sw_bit_q  <= crc_pkg::SW_BIT_RESET;
            state_q   <= crc_pkg::CRC_HOLD;
            cnt_q     <= '0;
            first_q   <= 1'b1;
            fs_prev_q <= 1'b1;
            ones_q    <= 1'b0;
        end else begin
            sw_bit_q  <= sw_bit_d;
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            first_q   <= first_d;
            fs_prev_q <= fs_prev_d;
            ones_q    <= ones_d;
        end
    end

    // Outputs.
    assign software_reset_bit = sw_bit_q;
    assign core_reset         = (state_q == crc_pkg::CRC_HOLD) ||
                                (state_q == crc_pkg::CRC_RELEASE);
    assign force_ones         = ones_q;
    assign status.core_reset  = core_reset;
    assign status.host_ready  = (state_q == crc_pkg::CRC_READY);
    assign status.first_frame = first_q;
    assign status.sources     = src;
endmodule

/* bench/crc_host_model.sv */
// Host model that frames the serial port once the block allows it.
`timescale 1ns/10ps
module crc_host_model (
    // Clock and readiness.
    input  wire logic ref_clk,
    input  wire logic host_ready,
    // Frame select, active low.
    output logic      frame_n
);
    initial frame_n = 1'b1;
    // Opens a frame only once the block reports the wait after reset is over.
    task automatic open_frame();
        while (host_ready !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        frame_n = 1'b0;
    endtask
    // Ends the frame.
    task automatic close_frame();
        @(negedge ref_clk);
        frame_n = 1'b1;
    endtask
endmodule

/* bench/crc_assertions.sv */
// Assertions on the ports of the reset sequencer.
`timescale 1ns/10ps
module crc_assertions #(
    parameter int HOLD_CYC = 4,
    parameter int WAIT_CYC = 80
) (
    // Design ports.
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire logic                 ext_reset_n,
    input wire logic                 sw_bit_we,
    input wire logic                 sw_bit_wdata,
    input wire logic                 frame_sync_chip_select_n,
    input wire logic                 software_reset_bit,
    input wire logic                 core_reset,
    input wire logic                 force_ones,
    input wire crc_pkg::crc_status_t status
);
    int free_q;
    int free_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Counts cycles since the core left reset, saturating.
    always_comb free_d = core_reset ? 0 : (free_q < 1000 ? free_q + 1 : free_q);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            free_q <= 0;
        end else begin
            free_q <= free_d;
        end
    end
    a_por_hold: assert property (disable iff (1'b0) reset |-> core_reset && software_reset_bit)
        else $error("core free during power-on reset");
    a_ext_hold: assert property (!ext_reset_n [*4] |-> core_reset)
        else $error("core free while pin low");
    a_sw_clear: assert property (sw_bit_we && !sw_bit_wdata && !core_reset
        |=> !software_reset_bit ##1 core_reset)
        else $error("zero write did not reset");
    a_sw_return: assert property ($fell(software_reset_bit) && ext_reset_n
        |-> ##[1:8] software_reset_bit)
        else $error("bit did not return to one");
    a_one_noop: assert property (ext_reset_n [*3] ##0 (sw_bit_we && sw_bit_wdata && !core_reset)
        |=> !core_reset)
        else $error("one write reset core");
    a_ready_time: assert property ($rose(status.host_ready) |-> free_q == WAIT_CYC)
        else $error("ready at wrong time");
    a_ready_free: assert property (status.host_ready |-> !core_reset
        && status.core_reset == core_reset)
        else $error("ready while core held");
    a_ones_end: assert property ((force_ones && frame_sync_chip_select_n)
        ##1 frame_sync_chip_select_n [*3] |-> !force_ones)
        else $error("ones beyond first frame");
    a_first_armed: assert property (core_reset |-> status.first_frame)
        else $error("first frame not armed during reset");
    a_src_ext: assert property (!ext_reset_n [*3] |-> status.sources[crc_pkg::SRC_EXT])
        else $error("pin source not shown");
    c_ext_reset: cover property ($fell(status.sources[crc_pkg::SRC_EXT]));
    c_sw_reset: cover property ($fell(software_reset_bit));
    c_first: cover property ($rose(force_ones));
    c_ready: cover property ($rose(status.host_ready));
endmodule
bind crc_top crc_assertions #(.HOLD_CYC(HOLD_CYC), .WAIT_CYC(WAIT_CYC)) i_crc_assertions (
    .ref_clk, .reset, .ext_reset_n, .sw_bit_we, .sw_bit_wdata, .frame_sync_chip_select_n,
    .software_reset_bit, .core_reset, .force_ones, .status);

/* bench/crc_top_tb_top.sv */
// Testbench for the reset sequencer with a host model on the serial port.
`timescale 1ns/10ps
module crc_top_tb_top;
    logic                 ref_clk = 1'b0;
    logic                 reset, ext_reset_n, sw_bit_we, sw_bit_wdata, frame_n, probe;
    logic                 software_reset_bit, core_reset, force_ones;
    crc_pkg::crc_status_t status;
    logic [2:0]           exp_q[$];
    int                   num_errors = 0;
    int                   cmp_count = 0;
    logic [31:0]          seed = 32'h88849e7f;
    crc_top #(.HOLD_CYC(2), .WAIT_CYC(4)) i_crc_top (.ref_clk, .reset, .ext_reset_n, .sw_bit_we,
        .sw_bit_wdata, .frame_sync_chip_select_n(frame_n), .software_reset_bit, .core_reset,
        .force_ones, .status);
    crc_host_model i_crc_host_model (.ref_clk, .host_ready(status.host_ready), .frame_n);
    // Clock and watchdog.
    initial forever #12.5 ref_clk = ~ref_clk;
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Reports a mismatch between a seen and an expected value.
    task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // Notes {core_reset, bit, ones} for the watcher.
    task automatic note(input logic [2:0] e);
        exp_q.push_back(e);
        probe = 1'b1;
        @(negedge ref_clk);
        probe = 1'b0;
    endtask
    // Watcher compares settled outputs with the oldest note.
    always @(posedge ref_clk) begin
        if (probe === 1'b1) begin
            #1;
            check("outputs", {core_reset, software_reset_bit, force_ones}, exp_q[0]);
            void'(exp_q.pop_front());
        end
    end
    task automatic wr(input logic v);
        sw_bit_wdata = v;
        sw_bit_we = 1'b1;
        @(negedge ref_clk);
        sw_bit_we = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic frame(input logic [2:0] e);
        i_crc_host_model.open_frame();
        repeat (3) @(negedge ref_clk);
        note(e);
        i_crc_host_model.close_frame();
        repeat (4) @(negedge ref_clk);
    endtask
    // Main sequence.
    initial begin
        reset = 1'b1;
        ext_reset_n = 1'b1;
        sw_bit_we = 1'b0;
        sw_bit_wdata = 1'b1;
        probe = 1'b0;
        repeat (11) @(negedge ref_clk);
        note(3'b110);
        reset = 1'b0;
        frame(3'b011);
        frame(3'b010);
        wr(1'b0);
        frame(3'b011);
        for (int i = 0; i < 4; i++) begin
            wr(1'b1);
            sw_bit_wdata = 1'(rnd()); // Random data without a strobe must do nothing.
            repeat (1 + rnd() % 3) @(negedge ref_clk);
        end
        frame(3'b010);
        ext_reset_n = 1'b0;
        @(negedge ref_clk);
        ext_reset_n = 1'b1;
        // Let the pin pass the synchroniser so the host sees readiness drop first.
        repeat (3) @(negedge ref_clk);
        frame(3'b011);
        ext_reset_n = 1'b0;
        wr(1'b0);
        repeat (5 + rnd() % 8) @(negedge ref_clk);
        note(3'b100);
        ext_reset_n = 1'b1;
        frame(3'b011);
        reset = 1'b1;
        note(3'b110);
        reset = 1'b0;
        frame(3'b011);
        conclude();
    end
endmodule
